// File: verilog/tsr_pkg.sv
// constants shared by the temperature sensor register set
// assumes a single 40 MHz system clock domain; the serial clock is sampled, not used as a clock
package tsr_pkg;

  // ----------------------------------------------------------------
  // command codes and register reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_TEMP = 8'h00;
  localparam logic [7:0] CMD_CFG = 8'h01;
  localparam logic [7:0] TEMP_RST = 8'h00;
  localparam logic [7:0] CFG_RST = 8'h00;

  // ----------------------------------------------------------------
  // configuration field positions
  // ----------------------------------------------------------------
  localparam int CFG_STANDBY_BIT = 7;
  localparam int CFG_READY_BIT = 6;
  localparam int CFG_RSVD_MSB = 5;

  // ----------------------------------------------------------------
  // serial link and temperature limits
  // ----------------------------------------------------------------
  localparam logic [6:0] SLAVE_ADDR_DEF = 7'h4D;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam int TEMP_MAX_DEG = 127;
  localparam int TEMP_MIN_DEG = -128;
  localparam logic [7:0] TEMP_MAX = 8'h7F;
  localparam logic [7:0] TEMP_MIN = 8'h80;
  localparam int CONV_FRAC_BITS = 2;
  localparam int CONV_WIDTH = 12;

  // ----------------------------------------------------------------
  // serial slave states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_ADDR = 4'b0001,
    ST_AACK = 4'b0010,
    ST_CMD = 4'b0011,
    ST_CACK = 4'b0100,
    ST_WDATA = 4'b0101,
    ST_WACK = 4'b0110,
    ST_READ = 4'b0111,
    ST_MACK = 4'b1000
  } tsr_state_type;

endpackage

// File: verilog/tsr_sensor_regs.sv
// temperature sensor register set with its two-wire serial slave
// assumes the conversion front end runs on SYS_CLK; SCL and SDA_IN come from the pins
//
// Overview of operation
// - command 00h selects temperature for reads, 01h selects configuration for reads and writes.
// - configuration bit 7 is the writable standby switch; bits 5..0 read zero.
// - configuration bit 6 is read-only data ready, cleared at reset and on standby.
// - temperature is an 8-bit two's-complement value, one degree per count.
// - temperature changes only by a finished conversion, never by a bus write.
// - readings at or above 127 degrees register as 0111 1111.
// - fractional readings truncate toward negative infinity.
// - both registers are eight bits and reset to zero.
// - a new result is loaded into temperature as data ready goes high.
// - standby halts conversions and freezes temperature; the serial port keeps working.
// - a receive byte returns the register chosen by the last command byte.
// - the device answers only its own 7-bit address, 1001 101b by default.
`timescale 1ns/1ps

module tsr_sensor_regs #(
  parameter logic [6:0] SLAVE_ADDR = tsr_pkg::SLAVE_ADDR_DEF,
  parameter int FRAC_BITS = tsr_pkg::CONV_FRAC_BITS,
  parameter int RAW_W = tsr_pkg::CONV_WIDTH
) (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic CLK_EN,
  input wire logic SCL,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  input wire logic CONV_VALID,
  input wire logic signed [RAW_W-1:0] CONV_VALUE,
  output logic CONV_RUN
);

  localparam logic signed [RAW_W-1:0] RAW_MAX = RAW_W'(tsr_pkg::TEMP_MAX_DEG);
  localparam logic signed [RAW_W-1:0] RAW_MIN = RAW_W'(tsr_pkg::TEMP_MIN_DEG);

  tsr_pkg::tsr_state_type state;
  logic [2:0] scl_sync;
  logic [2:0] sda_sync;
  logic [3:0] bit_cnt;
  logic [7:0] shreg;
  logic [7:0] tx;
  logic [7:0] pointer;
  logic [7:0] temp;
  logic rw;
  logic mack_ok;
  logic standby;
  logic ready;
  logic sda_oe;
  logic sda_out;
  logic conv_run;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic byte_done;
  logic cfg_wr;
  logic conv_take;
  logic [7:0] rd_value;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // register read decode, used at both points where a read byte is loaded
  function automatic logic [7:0] reg_read(input logic [7:0] ptr, input logic [7:0] t, input logic sb,
                                          input logic rdy);
    logic [7:0] v;
    v = 8'h00;
    if (ptr == tsr_pkg::CMD_TEMP)
      v = t;
    else if (ptr == tsr_pkg::CMD_CFG)
      v = {sb, rdy, 6'h00};
    return v;
  endfunction

  // arithmetic shift floors toward minus infinity, then clamp to the 8-bit range
  function automatic logic [7:0] sat_temp(input logic signed [RAW_W-1:0] raw);
    logic signed [RAW_W-1:0] fl;
    logic [7:0] v;
    fl = raw >>> FRAC_BITS;
    v = fl[7:0];
    if (fl > RAW_MAX)
      v = tsr_pkg::TEMP_MAX;
    else if (fl < RAW_MIN)
      v = tsr_pkg::TEMP_MIN;
    return v;
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers and condition detection
  // ----------------------------------------------------------------
  // stage 0 feeds stage 1 only; edges compare stages 1 and 2
  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      scl_sync <= 3'h7;
      sda_sync <= 3'h7;
    end
    else if (CLK_EN)
    begin
      scl_sync <= {scl_sync[1:0], SCL};
      sda_sync <= {sda_sync[1:0], SDA_IN};
    end
  end

  assign scl_rise = scl_sync[1] & ~scl_sync[2];
  assign scl_fall = ~scl_sync[1] & scl_sync[2];
  assign start_seen = scl_sync[1] & scl_sync[2] & ~sda_sync[1] & sda_sync[2];
  assign stop_seen = scl_sync[1] & scl_sync[2] & sda_sync[1] & ~sda_sync[2];
  assign byte_done = scl_fall && (bit_cnt == tsr_pkg::BITS_PER_BYTE);
  assign cfg_wr = byte_done && (state == tsr_pkg::ST_WDATA) && (pointer == tsr_pkg::CMD_CFG);
  // a standby write in the same cycle blocks the result, so ready never sets in standby
  assign conv_take = CLK_EN && CONV_VALID && !standby && !(cfg_wr && shreg[tsr_pkg::CFG_STANDBY_BIT]);
  assign rd_value = reg_read(pointer, temp, standby, ready);

  // ----------------------------------------------------------------
  // serial slave state machine
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      state <= tsr_pkg::ST_IDLE;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      tx <= 8'h00;
      rw <= 1'b0;
      mack_ok <= 1'b0;
      sda_oe <= 1'b0;
    end
    else if (CLK_EN)
    begin
      if (start_seen)
      begin
        state <= tsr_pkg::ST_ADDR;
        bit_cnt <= 4'h0;
        sda_oe <= 1'b0;
      end
      else if (stop_seen)
      begin
        state <= tsr_pkg::ST_IDLE;
        sda_oe <= 1'b0;
      end
      else if (scl_rise)
      begin
        if (state == tsr_pkg::ST_MACK)
          mack_ok <= ~sda_sync[1];
        else if (state inside {tsr_pkg::ST_ADDR, tsr_pkg::ST_CMD, tsr_pkg::ST_WDATA, tsr_pkg::ST_READ})
        begin
          shreg <= {shreg[6:0], sda_sync[1]};
          bit_cnt <= bit_cnt + 4'h1;
        end
      end
      else if (scl_fall)
      begin
        unique case (state)
          tsr_pkg::ST_IDLE:
            sda_oe <= 1'b0;
          tsr_pkg::ST_ADDR:
            if (byte_done)
            begin
              if (shreg[7:1] == SLAVE_ADDR)
              begin
                sda_oe <= 1'b1;
                rw <= shreg[0];
                state <= tsr_pkg::ST_AACK;
              end
              else
                state <= tsr_pkg::ST_IDLE;
            end
          tsr_pkg::ST_AACK:
          begin
            bit_cnt <= 4'h0;
            if (rw)
            begin
              // receive byte and read byte both answer from the held pointer
              sda_oe <= ~rd_value[7];
              tx <= {rd_value[6:0], 1'b0};
              state <= tsr_pkg::ST_READ;
            end
            else
            begin
              sda_oe <= 1'b0;
              state <= tsr_pkg::ST_CMD;
            end
          end
          tsr_pkg::ST_CMD:
            if (byte_done)
            begin
              sda_oe <= 1'b1;
              state <= tsr_pkg::ST_CACK;
            end
          tsr_pkg::ST_CACK, tsr_pkg::ST_WACK:
          begin
            sda_oe <= 1'b0;
            bit_cnt <= 4'h0;
            state <= tsr_pkg::ST_WDATA;
          end
          tsr_pkg::ST_WDATA:
            if (byte_done)
            begin
              sda_oe <= 1'b1;
              state <= tsr_pkg::ST_WACK;
            end
          tsr_pkg::ST_READ:
            if (byte_done)
            begin
              sda_oe <= 1'b0;
              state <= tsr_pkg::ST_MACK;
            end
            else
            begin
              sda_oe <= ~tx[7];
              tx <= {tx[6:0], 1'b0};
            end
          tsr_pkg::ST_MACK:
          begin
            bit_cnt <= 4'h0;
            if (mack_ok)
            begin
              sda_oe <= ~rd_value[7];
              tx <= {rd_value[6:0], 1'b0};
              state <= tsr_pkg::ST_READ;
            end
            else
            begin
              sda_oe <= 1'b0;
              state <= tsr_pkg::ST_IDLE;
            end
          end
          default:
          begin
            sda_oe <= 1'b0;
            state <= tsr_pkg::ST_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // command pointer, configuration and temperature registers
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
      pointer <= tsr_pkg::CMD_TEMP;
    else if (CLK_EN && byte_done && state == tsr_pkg::ST_CMD)
      pointer <= shreg;
  end

  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      standby <= tsr_pkg::CFG_RST[tsr_pkg::CFG_STANDBY_BIT];
      ready <= tsr_pkg::CFG_RST[tsr_pkg::CFG_READY_BIT];
    end
    else if (CLK_EN)
    begin
      if (cfg_wr)
        standby <= shreg[tsr_pkg::CFG_STANDBY_BIT];
      if (cfg_wr && shreg[tsr_pkg::CFG_STANDBY_BIT])
        ready <= 1'b0;
      else if (conv_take)
        ready <= 1'b1;
    end
  end

  // only the conversion path writes temperature; bus writes to 00h are dropped
  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
      temp <= tsr_pkg::TEMP_RST;
    else if (conv_take)
      temp <= sat_temp(CONV_VALUE);
  end

  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      conv_run <= 1'b0;
      sda_out <= 1'b0;
    end
    else if (CLK_EN)
    begin
      conv_run <= ~standby;
      sda_out <= 1'b0;
    end
  end

  assign SDA_OE = sda_oe;
  assign SDA_OUT = sda_out;
  assign CONV_RUN = conv_run;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_conv_taken;
    conv_take;
  endsequence

  sequence s_addr_miss;
    CLK_EN && !start_seen && !stop_seen && byte_done && state == tsr_pkg::ST_ADDR && shreg[7:1] != SLAVE_ADDR;
  endsequence

  cfg_reserved_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    pointer == tsr_pkg::CMD_CFG |-> rd_value[tsr_pkg::CFG_RSVD_MSB:0] == 6'h00)
    else $error("reserved configuration bits not zero");

  ready_standby_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N) standby |-> !ready)
    else $error("data ready set while in standby");

  temp_load_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    s_conv_taken |=> ready && temp == sat_temp($past(CONV_VALUE)))
    else $error("conversion result not loaded with data ready");

  temp_frozen_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N) standby |=> $stable(temp))
    else $error("temperature changed in standby");

  temp_readonly_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N) !conv_take |=> $stable(temp))
    else $error("temperature changed without a conversion");

  temp_sat_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    (s_conv_taken and ((CONV_VALUE >>> FRAC_BITS) >= RAW_MAX)) |=> temp == tsr_pkg::TEMP_MAX)
    else $error("temperature not saturated at 127");

  temp_floor_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    (s_conv_taken and ((CONV_VALUE >>> FRAC_BITS) < RAW_MAX) and ((CONV_VALUE >>> FRAC_BITS) >= RAW_MIN))
    |=> temp == $past(CONV_VALUE[FRAC_BITS+7:FRAC_BITS]))
    else $error("temperature not floored");

  addr_miss_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    s_addr_miss |=> state == tsr_pkg::ST_IDLE && !SDA_OE)
    else $error("foreign address acknowledged");

  cmd_pointer_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    (CLK_EN && !start_seen && !stop_seen && byte_done && state == tsr_pkg::ST_CMD)
    |=> pointer == $past(shreg) && SDA_OE)
    else $error("command byte not latched and acknowledged");

  cfg_write_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    (CLK_EN && !start_seen && !stop_seen && cfg_wr) |=> standby == $past(shreg[7]))
    else $error("configuration write lost");

endmodule

// File: verification/tsr_host_model.sv
// serial bus host that frames transfers for the sensor's slave port
// assumes SDA_OE pulls the wire low and a pull-up holds it high otherwise
`timescale 1ns/1ps

module tsr_host_model (
  input wire logic SDA_OE,
  output logic SCL,
  output logic SDA_IN
);
  logic sda_m;

  // ------------------------------------------------------------
  // wire and idle level
  // ------------------------------------------------------------
  // pull-up: a released wire reads high, never the last driven value
  assign SDA_IN = sda_m & ~SDA_OE;

  initial
  begin
    SCL = 1'b1;
    sda_m = 1'b1;
  end

  // ------------------------------------------------------------
  // bit and byte framing
  // ------------------------------------------------------------
  // data moves only while the clock is low; the clock rests high between frames
  task automatic bit_io(input logic b, output logic r);
    #50 sda_m = b;
    #50 SCL = 1'b1;
    r = SDA_IN;
    #100 SCL = 1'b0;
  endtask

  task automatic start_cond;
    #50 sda_m = 1'b1;
    #50 SCL = 1'b1;
    #100 sda_m = 1'b0;
    #100 SCL = 1'b0;
  endtask

  task automatic stop_cond;
    #50 sda_m = 1'b0;
    #50 SCL = 1'b1;
    #100 sda_m = 1'b1;
    #100;
  endtask

  // msb first, ninth clock carries the acknowledge
  task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] r, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(d[i], b);
      r[i] = b;
    end
    bit_io(last, ack);
  endtask
endmodule

// File: verification/tsr_sensor_regs_tb_top.sv
// self-checking bench for the sensor register set
// assumes tsr_host_model drives the serial pins and the bench feeds conversions
`timescale 1ns/1ps

module tsr_sensor_regs_tb_top;
  localparam logic [6:0] ADDR = tsr_pkg::SLAVE_ADDR_DEF;
  logic sys_clk;
  logic rst_n;
  logic clk_en;
  logic scl;
  logic sda;
  logic sda_out;
  logic sda_oe;
  logic conv_valid;
  logic [11:0] conv_value;
  logic conv_run;
  logic [11:0] v;
  logic [7:0] r;
  logic a;
  int miscompares;
  int check_count;
  // edge cases: 126.5, 127, 130, 25.25, 0.5, -0.25, -25.25, -65, below -128
  logic [11:0] corner [9] = '{12'h1FA, 12'h1FC, 12'h208, 12'h065, 12'h002, 12'hFFF, 12'hF9B, 12'hEFC, 12'h800};

  tsr_sensor_regs tsr_sensor_regs_i (
    .SYS_CLK(sys_clk),
    .RST_N(rst_n),
    .CLK_EN(clk_en),
    .SCL(scl),
    .SDA_IN(sda),
    .SDA_OUT(sda_out),
    .SDA_OE(sda_oe),
    .CONV_VALID(conv_valid),
    .CONV_VALUE(conv_value),
    .CONV_RUN(conv_run)
  );

  tsr_host_model tsr_host_model_i (
    .SDA_OE(sda_oe),
    .SCL(scl),
    .SDA_IN(sda)
  );

  always #12.5 sys_clk = ~sys_clk;

  // ------------------------------------------------------------
  // expectations and checks
  // ------------------------------------------------------------
  // floor of quarter degrees, then clamp to the 8-bit range
  function automatic logic [7:0] exp_temp(input logic signed [11:0] q);
    logic signed [11:0] f;
    f = q >>> 2;
    if (f > 127)
      return 8'h7F;
    if (f < -128)
      return 8'h80;
    return f[7:0];
  endfunction

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic conclude;
    if (miscompares == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ------------------------------------------------------------
  // bus transfers
  // ------------------------------------------------------------
  task automatic frame_hdr(input logic [7:0] cmd);
    tsr_host_model_i.start_cond();
    tsr_host_model_i.xfer({ADDR, 1'b0}, 1'b1, r, a);
    check({7'h00, a}, 8'h00);
    tsr_host_model_i.xfer(cmd, 1'b1, r, a);
    check({7'h00, a}, 8'h00);
  endtask

  task automatic wr(input logic [7:0] cmd, input logic [7:0] d);
    frame_hdr(cmd);
    tsr_host_model_i.xfer(d, 1'b1, r, a);
    check({7'h00, a}, 8'h00);
    tsr_host_model_i.stop_cond();
  endtask

  // receive byte: no command, last pointer decides
  task automatic rcv_chk(input logic [7:0] exp);
    tsr_host_model_i.start_cond();
    tsr_host_model_i.xfer({ADDR, 1'b1}, 1'b1, r, a);
    check({7'h00, a}, 8'h00);
    tsr_host_model_i.xfer(8'hFF, 1'b1, r, a);
    tsr_host_model_i.stop_cond();
    check(r, exp);
  endtask

  task automatic rd_chk(input logic [7:0] cmd, input logic [7:0] exp);
    frame_hdr(cmd);
    rcv_chk(exp);
  endtask

  task automatic conv(input logic [11:0] q);
    @(posedge sys_clk);
    #2 conv_valid = 1'b1;
    conv_value = q;
    @(posedge sys_clk);
    #2 conv_valid = 1'b0;
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    sys_clk = 1'b0;
    rst_n = 1'b0;
    clk_en = 1'b1;
    conv_valid = 1'b0;
    conv_value = 12'h000;
    miscompares = 0;
    check_count = 0;
    void'($urandom(46758));
    repeat (4) @(posedge sys_clk);
    #2 rst_n = 1'b1;
    repeat (4) @(posedge sys_clk);
    // keep every pin change off the sampling edge
    #2;
    rcv_chk(tsr_pkg::TEMP_RST);
    rd_chk(tsr_pkg::CMD_CFG, tsr_pkg::CFG_RST);
    check({7'h00, conv_run}, 8'h01);
    for (int i = 0; i < 25; i++)
    begin
      v = (i < 9) ? corner[i] : 12'($urandom_range(0, 4095));
      conv(v);
      rd_chk(tsr_pkg::CMD_TEMP, exp_temp(v));
    end
    rd_chk(tsr_pkg::CMD_CFG, 8'h40);
    rcv_chk(8'h40);
    // master ack on a read must resend the selected register
    tsr_host_model_i.start_cond();
    tsr_host_model_i.xfer({ADDR, 1'b1}, 1'b1, r, a);
    check({7'h00, a}, 8'h00);
    tsr_host_model_i.xfer(8'hFF, 1'b0, r, a);
    check(r, 8'h40);
    tsr_host_model_i.xfer(8'hFF, 1'b1, r, a);
    tsr_host_model_i.stop_cond();
    check(r, 8'h40);
    wr(tsr_pkg::CMD_TEMP, ~exp_temp(v));
    rd_chk(tsr_pkg::CMD_TEMP, exp_temp(v));
    wr(tsr_pkg::CMD_CFG, 8'hFF);
    rd_chk(tsr_pkg::CMD_CFG, 8'h80);
    check({7'h00, conv_run}, 8'h00);
    conv(~v);
    rd_chk(tsr_pkg::CMD_TEMP, exp_temp(v));
    wr(tsr_pkg::CMD_CFG, 8'h00);
    rd_chk(tsr_pkg::CMD_CFG, 8'h00);
    check({7'h00, conv_run}, 8'h01);
    conv(12'h040);
    rd_chk(tsr_pkg::CMD_CFG, 8'h40);
    rd_chk(tsr_pkg::CMD_TEMP, 8'h10);
    // a result offered while the clock enable is low must be lost
    clk_en = 1'b0;
    conv(12'h100);
    clk_en = 1'b1;
    rd_chk(tsr_pkg::CMD_TEMP, 8'h10);
    check({7'h00, sda_out}, 8'h00);
    rd_chk(8'h5A, 8'h00);
    tsr_host_model_i.start_cond();
    tsr_host_model_i.xfer({7'h4C, 1'b0}, 1'b1, r, a);
    check({7'h00, a}, 8'h01);
    tsr_host_model_i.stop_cond();
    // second reset in mid-run: registers and pointer must return to zero
    rst_n = 1'b0;
    repeat (4) @(posedge sys_clk);
    #2 rst_n = 1'b1;
    repeat (4) @(posedge sys_clk);
    #2;
    rcv_chk(tsr_pkg::TEMP_RST);
    rd_chk(tsr_pkg::CMD_CFG, tsr_pkg::CFG_RST);
    conclude();
  end

  // hang guard well beyond the test's run of about 13300 cycles
  initial
  begin
    repeat (100000) @(posedge sys_clk);
    miscompares++;
    conclude();
  end
endmodule
